// [verilog/lcdsm_top.sv]
// Local design decision: the APB interface to the registers.
`default_nettype none

module lcdsm_top
    import lcdsm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire lcdsm_apb_req_type apb_req,
    output lcdsm_apb_rsp_type apb_rsp,
    input wire logic lcd_clk_tick,
    input wire logic deep_sleep_mode,
    output lcdsm_glass_type glass
);

    typedef struct packed {
        logic [7:0] main_cfg;
        logic [7:0] clk_cfg;
        logic [7:0] seg_en_a;
        logic [7:0] seg_en_b;
        logic [7:0] aux_x;
        logic [7:0] aux_y;
        logic [7:0] ptr;
        logic [7:0] data;
        logic load_pending;
        logic [5:0] scan_idx;
        logic [5:0] scan_prev;
        logic [MEM_DEPTH-1:0][7:0] shadow;
        logic [11:0] blink_cnt;
        logic blink_phase;
        logic [5:0] frame_cnt;
        lcdsm_apb_rsp_type rsp;
        lcdsm_glass_type glass;
    } lcdsm_state_type;

    lcdsm_state_type st_r;
    lcdsm_state_type st_nxt;

    logic acc;
    logic mem_wr;
    logic [5:0] mem_rd_addr;
    logic [7:0] mem_rd_data;
    logic [7:0] scan_data;
    logic disp_ok;
    logic blink_vis;
    logic auto_blink;
    logic [11:0] blink_half;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode shared by the read and write paths.
    function automatic logic lcdsm_hit(input logic [11:0] a, input logic [7:0] idx);
        return a[1:0] == 2'h0 && a[11:10] == 2'h0 && a[9:2] == idx;
    endfunction : lcdsm_hit

    function automatic logic lcdsm_mapped(input logic [11:0] a);
        return lcdsm_hit(a, IDX_MAIN_CFG) || lcdsm_hit(a, IDX_CLK_CFG)
            || lcdsm_hit(a, IDX_SEG_EN_A) || lcdsm_hit(a, IDX_AUX_X)
            || lcdsm_hit(a, IDX_PTR) || lcdsm_hit(a, IDX_DATA)
            || lcdsm_hit(a, IDX_AUX_Y) || lcdsm_hit(a, IDX_SEG_EN_B);
    endfunction : lcdsm_mapped

    ////////////////////////////////////////////////////////////////////////////////
    // Segment memory with a port for software and a port for the display scan.
    assign acc = apb_req.psel && apb_req.penable && st_r.rsp.pready;
    assign mem_wr = acc && apb_req.pwrite && lcdsm_hit(apb_req.paddr, IDX_PTR)
        && apb_req.pwdata[PTR_WRITE];
    assign mem_rd_addr = apb_req.pwdata[5:0];

    lcdsm_mem #(
        .DEPTH(MEM_DEPTH)
    ) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .clear(st_r.main_cfg[MAIN_CLEAR]),
        .wr_en(mem_wr),
        .wr_addr(apb_req.pwdata[5:0]),
        .wdata(st_r.data),
        .rd_addr_a(mem_rd_addr),
        .rd_addr_b(st_r.scan_idx),
        .rd_data_a(mem_rd_data),
        .rd_data_b(scan_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Display gating and blink decode.
    always_comb begin
        if (deep_sleep_mode) begin
            disp_ok = !st_r.main_cfg[MAIN_SLEEP_DIS] && st_r.main_cfg[MAIN_DISP_EN];
        end else begin
            disp_ok = st_r.main_cfg[MAIN_DISP_EN];
        end
        auto_blink = st_r.main_cfg[MAIN_BLINK_EN]
            && st_r.clk_cfg[CLK_MODE_LO+1];
        blink_half = BLINK_HALF_FIX;
        if (st_r.clk_cfg[CLK_MODE_LO +: 2] == BLINK_AUTO_SEL) begin
            unique case (st_r.clk_cfg[CLK_RATE_LO +: 2])
                2'h0: blink_half = BLINK_HALF_R0;
                2'h1: blink_half = BLINK_HALF_R1;
                2'h2: blink_half = BLINK_HALF_R2;
                2'h3: blink_half = BLINK_HALF_R3;
            endcase
        end
        if (!st_r.main_cfg[MAIN_BLINK_EN]) begin
            blink_vis = 1'b1;
        end else begin
            unique case (st_r.clk_cfg[CLK_MODE_LO +: 2])
                BLINK_SW_OFF: blink_vis = 1'b0;
                BLINK_SW_ON: blink_vis = 1'b1;
                BLINK_AUTO_SEL, BLINK_AUTO_FIX: blink_vis = st_r.blink_phase;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        st_nxt = st_r;
        st_nxt.main_cfg[MAIN_CLEAR] = 1'b0;
        st_nxt.rsp.pready = apb_req.psel && apb_req.penable && !st_r.rsp.pready;
        st_nxt.rsp.pslverr = 1'b0;
        st_nxt.glass.frame_tick = 1'b0;
        if (apb_req.psel && apb_req.penable && !st_r.rsp.pready) begin
            st_nxt.rsp.pslverr = !lcdsm_mapped(apb_req.paddr);
            st_nxt.rsp.prdata = 32'h0000_0000;
            if (!apb_req.pwrite) begin
                if (lcdsm_hit(apb_req.paddr, IDX_MAIN_CFG)) begin
                    st_nxt.rsp.prdata[7:0] = st_r.main_cfg;
                end
                if (lcdsm_hit(apb_req.paddr, IDX_CLK_CFG)) begin
                    st_nxt.rsp.prdata[7:0] = st_r.clk_cfg;
                end
                if (lcdsm_hit(apb_req.paddr, IDX_SEG_EN_A)) begin
                    st_nxt.rsp.prdata[7:0] = st_r.seg_en_a;
                end
                if (lcdsm_hit(apb_req.paddr, IDX_AUX_X)) begin
                    st_nxt.rsp.prdata[7:0] = st_r.aux_x;
                end
                if (lcdsm_hit(apb_req.paddr, IDX_PTR)) begin
                    st_nxt.rsp.prdata[7:0] = st_r.ptr;
                end
                if (lcdsm_hit(apb_req.paddr, IDX_DATA)) begin
                    st_nxt.rsp.prdata[7:0] = st_r.data;
                end
                if (lcdsm_hit(apb_req.paddr, IDX_AUX_Y)) begin
                    st_nxt.rsp.prdata[7:0] = st_r.aux_y;
                end
                if (lcdsm_hit(apb_req.paddr, IDX_SEG_EN_B)) begin
                    st_nxt.rsp.prdata[7:0] = st_r.seg_en_b;
                end
            end
        end
        // A pending pointer read lands in the data register.
        st_nxt.load_pending = 1'b0;
        if (st_r.load_pending) begin
            st_nxt.data = mem_rd_data;
        end
        if (acc && apb_req.pwrite) begin
            if (lcdsm_hit(apb_req.paddr, IDX_MAIN_CFG)) begin
                st_nxt.main_cfg = apb_req.pwdata[7:0];
            end
            if (lcdsm_hit(apb_req.paddr, IDX_CLK_CFG)) begin
                st_nxt.clk_cfg = apb_req.pwdata[7:0];
            end
            if (lcdsm_hit(apb_req.paddr, IDX_SEG_EN_A)) begin
                st_nxt.seg_en_a = apb_req.pwdata[7:0];
            end
            if (lcdsm_hit(apb_req.paddr, IDX_AUX_X)) begin
                st_nxt.aux_x = apb_req.pwdata[7:0];
            end
            if (lcdsm_hit(apb_req.paddr, IDX_PTR)) begin
                st_nxt.ptr = apb_req.pwdata[7:0] & PTR_MASK;
                st_nxt.load_pending = !apb_req.pwdata[PTR_WRITE];
            end
            if (lcdsm_hit(apb_req.paddr, IDX_DATA)) begin
                st_nxt.data = apb_req.pwdata[7:0];
            end
            if (lcdsm_hit(apb_req.paddr, IDX_AUX_Y)) begin
                st_nxt.aux_y = apb_req.pwdata[7:0];
            end
            if (lcdsm_hit(apb_req.paddr, IDX_SEG_EN_B)) begin
                st_nxt.seg_en_b = apb_req.pwdata[7:0];
            end
        end
        // Scan copies memory into the displayed copy unless frozen.
        st_nxt.scan_prev = st_r.scan_idx;
        st_nxt.scan_idx = (st_r.scan_idx == 6'(MEM_DEPTH - 1)) ? 6'h00 : st_r.scan_idx + 6'h01;
        if (!st_r.aux_y[AUX_Y_FREEZE]) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                if (st_r.scan_prev == 6'(i)) begin
                    st_nxt.shadow[i] = scan_data;
                end
            end
        end
        // Automatic blink and frame timing run from LCD clock ticks.
        if (!auto_blink) begin
            st_nxt.blink_cnt = 12'h000;
            st_nxt.blink_phase = 1'b1;
        end else if (lcd_clk_tick) begin
            if (st_r.blink_cnt >= blink_half - 12'h001) begin
                st_nxt.blink_cnt = 12'h000;
                st_nxt.blink_phase = !st_r.blink_phase;
            end else begin
                st_nxt.blink_cnt = st_r.blink_cnt + 12'h001;
            end
        end
        if (lcd_clk_tick) begin
            if (st_r.frame_cnt >= 6'((7'(st_r.clk_cfg[CLK_FD_LO +: 4]) + 7'h01)
                                     * 7'(FRAME_TICK_SCALE)) - 6'h01) begin
                st_nxt.frame_cnt = 6'h00;
                st_nxt.glass.frame_tick = 1'b1;
            end else begin
                st_nxt.frame_cnt = st_r.frame_cnt + 6'h01;
            end
        end
        // Pin outputs; off phases blank the drive and leave memory alone.
        for (int l = 0; l < SEG_LINES; l++) begin
            st_nxt.glass.seg_drive[l] = (disp_ok && blink_vis)
                ? st_r.shadow[l / 2][(l % 2) * 4 +: 4] : 4'h0;
        end
        st_nxt.glass.display_on = disp_ok && blink_vis;
        st_nxt.glass.pin28_bp = st_r.main_cfg[MAIN_MUX_LO +: 2] == MUX_3X
            || st_r.main_cfg[MAIN_MUX_LO +: 2] == MUX_4X;
        st_nxt.glass.pin27_bp = st_r.main_cfg[MAIN_MUX_LO +: 2] == MUX_4X;
        unique case (st_r.main_cfg[MAIN_MUX_LO +: 2])
            MUX_4X: st_nxt.glass.bp_active = 4'hF;
            MUX_3X: st_nxt.glass.bp_active = 4'h7;
            default: st_nxt.glass.bp_active = 4'h3;
        endcase
        st_nxt.glass.line_is_lcd[15:0] = 16'hFFFF;
        st_nxt.glass.line_is_lcd[19:16] = st_r.seg_en_b[3:0];
        st_nxt.glass.line_is_lcd[25:20] = st_r.seg_en_a[7:2];
        st_nxt.glass.line_is_lcd[26] = 1'b1;
        st_nxt.glass.line_is_lcd[27] = !st_nxt.glass.pin27_bp;
        st_nxt.glass.line_is_lcd[28] = !st_nxt.glass.pin28_bp;
        st_nxt.glass.ext_ladder = st_r.aux_x[AUX_X_EXT_LADDER];
        st_nxt.glass.bias_comp_en = !st_r.aux_x[AUX_X_EXT_LADDER];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign apb_rsp = st_r.rsp;
    assign glass = st_r.glass;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pready_one_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready
        |=> apb_rsp.pready) else $error("pready not given after one wait");
    a_ptr_rsvd_zero: assert property (st_r.ptr[PTR_RSVD] == 1'b0)
        else $error("pointer reserved bit set");
    a_clear_pulse: assert property (st_r.main_cfg[MAIN_CLEAR] |=> !st_r.main_cfg[MAIN_CLEAR])
        else $error("clear bit did not self-clear");
    a_freeze_holds: assert property (st_r.aux_y[AUX_Y_FREEZE] ##1 st_r.aux_y[AUX_Y_FREEZE]
        |-> $stable(st_r.shadow)) else $error("displayed copy changed while frozen");
    a_low_lines_lcd: assert property ($past(presetn)
        |-> glass.line_is_lcd[15:0] == 16'hFFFF) else $error("low segment lines not LCD");
    a_mux4_backplane: assert property (st_r.main_cfg[1:0] == MUX_4X |=> glass.bp_active == 4'hF
        && glass.pin27_bp && glass.pin28_bp) else $error("four-way mux backplanes wrong");
    a_sleep_blank: assert property (deep_sleep_mode && st_r.main_cfg[MAIN_SLEEP_DIS]
        |=> !glass.display_on && glass.seg_drive == '0) else $error("display on in sleep");
    a_sw_blink_off: assert property (st_r.main_cfg[MAIN_BLINK_EN]
        && st_r.clk_cfg[7:6] == BLINK_SW_OFF |=> glass.seg_drive == '0)
        else $error("software blink off not blank");
    a_ladder_follow: assert property (st_r.aux_x[AUX_X_EXT_LADDER] |=> glass.ext_ladder
        && !glass.bias_comp_en) else $error("ladder select not followed");
    a_read_loads: assert property (acc && apb_req.pwrite && lcdsm_hit(apb_req.paddr, IDX_PTR)
        && !apb_req.pwdata[PTR_WRITE] |=> st_r.load_pending ##1 st_r.data == $past(mem_rd_data))
        else $error("pointer read did not load data");

    // Bus, register and scan index checks.
    a_ready_single: assert property (apb_rsp.pready
        |=> !apb_rsp.pready)
        else $error("pready held too long");
    a_ready_needs_access: assert property (!(apb_req.psel && apb_req.penable)
        |=> !apb_rsp.pready)
        else $error("pready without access");
    a_unmapped_error: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready
        && !lcdsm_mapped(apb_req.paddr) |=> apb_rsp.pslverr)
        else $error("unmapped access without error");
    a_rdata_upper: assert property (apb_rsp.pready
        |-> apb_rsp.prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_data_hold: assert property (!st_r.load_pending
        && !(acc && apb_req.pwrite && lcdsm_hit(apb_req.paddr, IDX_DATA))
        |=> $stable(st_r.data)) else $error("data register changed");
    a_ptr_hold: assert property (!(acc && apb_req.pwrite
        && lcdsm_hit(apb_req.paddr, IDX_PTR)) |=> $stable(st_r.ptr))
        else $error("pointer changed without write");
    a_scan_in_range: assert property (int'(st_r.scan_idx) < MEM_DEPTH)
        else $error("scan index out of range");

    // Display checks.
    a_mux2_pins: assert property (!st_r.main_cfg[1]
        |=> !glass.pin28_bp && !glass.pin27_bp)
        else $error("two-way mux took shared pins");
    a_mux3_pins: assert property (st_r.main_cfg[1:0] == MUX_3X
        |=> glass.pin28_bp && !glass.pin27_bp && glass.bp_active == 4'h7)
        else $error("three-way mux pins wrong");
    a_mux4_lines: assert property (st_r.main_cfg[1:0] == MUX_4X
        |=> glass.line_is_lcd[28:27] == 2'h0)
        else $error("four-way mux left shared lines");
    a_sleep_shows: assert property (deep_sleep_mode && !st_r.main_cfg[MAIN_SLEEP_DIS]
        && st_r.main_cfg[MAIN_DISP_EN] && !st_r.main_cfg[MAIN_BLINK_EN] |=> glass.display_on)
        else $error("display off in sleep");
    a_disp_off_blank: assert property (!st_r.main_cfg[MAIN_DISP_EN]
        |=> !glass.display_on && glass.seg_drive == '0)
        else $error("display not blank when off");
    a_auto_off_blank: assert property (st_r.main_cfg[MAIN_BLINK_EN] && st_r.clk_cfg[7]
        && !st_r.blink_phase |=> glass.seg_drive == '0)
        else $error("blink off phase not blank");
    a_sw_on_shows: assert property (st_r.main_cfg[MAIN_BLINK_EN] && !deep_sleep_mode
        && st_r.clk_cfg[7:6] == BLINK_SW_ON && st_r.main_cfg[MAIN_DISP_EN] |=> glass.display_on)
        else $error("software blink on not shown");
    a_phase_on_tick: assert property (auto_blink && !lcd_clk_tick
        |=> $stable(st_r.blink_phase))
        else $error("blink phase moved without tick");
    a_phase_idle: assert property ($past(presetn) && !auto_blink
        |=> st_r.blink_phase)
        else $error("blink phase low outside automatic blink");
    a_frame_pulse: assert property (glass.frame_tick
        |=> !glass.frame_tick)
        else $error("frame tick longer than one cycle");
    a_frame_on_tick: assert property (!lcd_clk_tick
        |=> !glass.frame_tick)
        else $error("frame tick without clock tick");
    a_ladder_off: assert property ($past(presetn) && !st_r.aux_x[AUX_X_EXT_LADDER]
        |=> !glass.ext_ladder && glass.bias_comp_en)
        else $error("internal ladder not followed");

    c_mem_write: cover property (mem_wr);
    c_mem_read: cover property (st_r.load_pending);
    c_auto_toggle: cover property (auto_blink && $changed(st_r.blink_phase));
    c_frozen_write: cover property (st_r.aux_y[AUX_Y_FREEZE] && mem_wr);
    c_sleep_shown: cover property (deep_sleep_mode && glass.display_on);

endmodule : lcdsm_top

`default_nettype wire

// [shared/lcdsm_pkg.sv]
`default_nettype none

package lcdsm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_MAIN_CFG = 8'h95;
    localparam logic [7:0] IDX_CLK_CFG = 8'h96;
    localparam logic [7:0] IDX_SEG_EN_A = 8'h97;
    localparam logic [7:0] IDX_AUX_X = 8'h9C;
    localparam logic [7:0] IDX_PTR = 8'hAC;
    localparam logic [7:0] IDX_DATA = 8'hAE;
    localparam logic [7:0] IDX_AUX_Y = 8'hB1;
    localparam logic [7:0] IDX_SEG_EN_B = 8'hED;
    localparam logic [7:0] REG_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int unsigned MAIN_MUX_LO = 0;
    localparam int unsigned MAIN_BIAS = 2;
    localparam int unsigned MAIN_CLEAR = 3;
    localparam int unsigned MAIN_BLINK_EN = 4;
    localparam int unsigned MAIN_SLEEP_DIS = 5;
    localparam int unsigned MAIN_CLKSEL = 6;
    localparam int unsigned MAIN_DISP_EN = 7;
    localparam int unsigned CLK_FD_LO = 0;
    localparam int unsigned CLK_RATE_LO = 4;
    localparam int unsigned CLK_MODE_LO = 6;
    localparam int unsigned AUX_X_EXT_LADDER = 0;
    localparam int unsigned AUX_Y_FREEZE = 0;
    localparam int unsigned PTR_WRITE = 7;
    localparam int unsigned PTR_RSVD = 6;
    localparam logic [7:0] PTR_MASK = 8'hBF;

    ////////////////////////////////////////////////////////////////////////////////
    // Memory, lines and modes.
    localparam int unsigned MEM_DEPTH = 15;
    localparam int unsigned SEG_LINES = 29;
    localparam logic [1:0] MUX_3X = 2'h2;
    localparam logic [1:0] MUX_4X = 2'h3;
    localparam logic [1:0] BLINK_SW_OFF = 2'h0;
    localparam logic [1:0] BLINK_SW_ON = 2'h1;
    localparam logic [1:0] BLINK_AUTO_SEL = 2'h2;
    localparam logic [1:0] BLINK_AUTO_FIX = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // Blink half periods and frame scale, in LCD clock ticks.
    localparam logic [11:0] BLINK_HALF_R0 = 12'h400;
    localparam logic [11:0] BLINK_HALF_R1 = 12'h200;
    localparam logic [11:0] BLINK_HALF_R2 = 12'h100;
    localparam logic [11:0] BLINK_HALF_R3 = 12'h080;
    localparam logic [11:0] BLINK_HALF_FIX = 12'h800;
    localparam logic [5:0] FRAME_TICK_SCALE = 6'h02;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lcdsm_apb_req_type;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } lcdsm_apb_rsp_type;

    typedef struct packed {
        logic [SEG_LINES-1:0][3:0] seg_drive;
        logic [3:0] bp_active;
        logic [SEG_LINES-1:0] line_is_lcd;
        logic pin28_bp;
        logic pin27_bp;
        logic ext_ladder;
        logic bias_comp_en;
        logic display_on;
        logic frame_tick;
    } lcdsm_glass_type;

endpackage : lcdsm_pkg

`default_nettype wire

// [verilog/lcdsm_mem.sv]
`default_nettype none

module lcdsm_mem
    import lcdsm_pkg::*;
#(
    parameter int unsigned DEPTH = MEM_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [5:0] wr_addr,
    input wire logic [7:0] wdata,
    input wire logic [5:0] rd_addr_a,
    input wire logic [5:0] rd_addr_b,
    output logic [7:0] rd_data_a,
    output logic [7:0] rd_data_b
);

    typedef struct packed {
        logic [DEPTH-1:0][7:0] bytes;
        logic [7:0] rda;
        logic [7:0] rdb;
    } lcdsm_mem_state_type;

    lcdsm_mem_state_type st_r;
    lcdsm_mem_state_type st_nxt;

    // Returns the byte at an address, zero beyond the last byte.
    function automatic logic [7:0] lcdsm_fetch(input lcdsm_mem_state_type s,
                                               input logic [5:0] a);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < DEPTH; i++) begin
            if (a == 6'(i)) begin
                v = s.bytes[i];
            end
        end
        return v;
    endfunction : lcdsm_fetch

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < DEPTH; i++) begin
            if (clear) begin
                st_nxt.bytes[i] = 8'h00;
            end else if (wr_en && wr_addr == 6'(i)) begin
                st_nxt.bytes[i] = wdata;
            end
        end
        st_nxt.rda = lcdsm_fetch(st_r, rd_addr_a);
        st_nxt.rdb = lcdsm_fetch(st_r, rd_addr_b);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_a = st_r.rda;
    assign rd_data_b = st_r.rdb;

endmodule : lcdsm_mem

`default_nettype wire

// [tb/lcdsm_glass_model.sv]
`default_nettype none

module lcdsm_glass_model
    import lcdsm_pkg::*;
(
    input wire logic pclk,
    input wire lcdsm_glass_type glass,
    output logic blank,
    output logic [2:0] bp_used
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////////////
    // The glass shows nothing when every segment line is at rest.
    always_ff @(posedge pclk) begin
        blank <= ~|glass.seg_drive;
        bp_used <= 3'($countones(glass.bp_active));
    end
endmodule : lcdsm_glass_model

`default_nettype wire

// [tb/test_lcdsm_top.sv]
`default_nettype none

`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("FAIL %0t got %0h expected %0h", $time, got, exp); \
    end \
end

module test_lcdsm_top
    import lcdsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic pclk;
    logic presetn;
    lcdsm_apb_req_type req;
    lcdsm_apb_rsp_type rsp;
    logic lcd_clk_tick = 1'b0;
    logic deep_sleep_mode;
    lcdsm_glass_type glass;
    logic blank;
    logic [2:0] bp_used;
    logic [1:0] tdiv = 2'h0;
    logic [7:0] q;
    logic [7:0] d;
    logic e;
    int mismatches;
    int samples_checked;
    int cyc;
    int n;
    logic [11:0] hv [5];
    logic [7:0] ridx [8];

    lcdsm_top dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .lcd_clk_tick(lcd_clk_tick), .deep_sleep_mode(deep_sleep_mode), .glass(glass));
    lcdsm_glass_model model (.pclk(pclk), .glass(glass), .blank(blank), .bp_used(bp_used));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, LCD clock tick every fourth cycle, and a hang limit.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        tdiv <= tdiv + 2'h1;
        lcd_clk_tick <= (tdiv == 2'h3);
        cyc++;
        if (cyc == 90000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////////
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= {2'h0, idx, 2'h0};
        req.pwdata <= {24'h0, wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        q = rsp.prdata[7:0];
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        `CHK(q, exp)
    endtask : rd

    task automatic half();
        logic b;
        b = blank;
        n = 0;
        while (blank === b && n < 20000) begin
            @(posedge pclk);
            n++;
        end
    endtask : half

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence.
    initial begin
        req = '0;
        presetn = 1'b0;
        deep_sleep_mode = 1'b0;
        hv = '{BLINK_HALF_R0, BLINK_HALF_R1, BLINK_HALF_R2, BLINK_HALF_R3, BLINK_HALF_FIX};
        ridx = '{IDX_MAIN_CFG, IDX_CLK_CFG, IDX_SEG_EN_A, IDX_AUX_X, IDX_PTR, IDX_DATA,
            IDX_AUX_Y, IDX_SEG_EN_B};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ridx[i]) rd(ridx[i], REG_RESET);
        `CHK(glass.ext_ladder, 1'b0)
        `CHK(glass.line_is_lcd[15:0], 16'hFFFF)
        `CHK(glass.line_is_lcd[28:16], 13'h1C00)
        rd(8'h00, 8'h00);
        `CHK(e, 1'b1)
        wr(IDX_PTR, 8'h7F);
        rd(IDX_PTR, 8'h3F);
        $display("test reset done");
        wr(IDX_MAIN_CFG, 8'h80);
        for (int i = 0; i < 15; i++) begin
            wr(IDX_DATA, {~i[3:0], i[3:0]});
            wr(IDX_PTR, 8'h80 | 8'(i));
        end
        repeat (40) @(posedge pclk);
        for (int i = 0; i < 14; i++) begin
            `CHK(glass.seg_drive[2*i], i[3:0])
            `CHK(glass.seg_drive[2*i+1], ~i[3:0])
        end
        `CHK(glass.seg_drive[28], 4'hE)
        for (int i = 0; i < 15; i++) begin
            d = {~i[3:0], i[3:0]};
            wr(IDX_PTR, 8'(i));
            rd(IDX_DATA, d);
        end
        $display("test memory done");
        wr(IDX_AUX_Y, 8'h01);
        wr(IDX_DATA, 8'h5A);
        wr(IDX_PTR, 8'h80);
        repeat (40) @(posedge pclk);
        `CHK(glass.seg_drive[0], 4'h0)
        wr(IDX_AUX_Y, 8'h00);
        repeat (40) @(posedge pclk);
        `CHK(glass.seg_drive[0], 4'hA)
        $display("test freeze done");
        deep_sleep_mode <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(IDX_MAIN_CFG, {i[0], 1'b0, i[1], 5'h00});
            repeat (4) @(posedge pclk);
            `CHK(glass.display_on, i[0] & ~i[1])
        end
        deep_sleep_mode <= 1'b0;
        wr(IDX_MAIN_CFG, 8'h80);
        repeat (40) @(posedge pclk);
        `CHK(glass.seg_drive[1], 4'h5)
        $display("test sleep done");
        wr(IDX_MAIN_CFG, 8'h90);
        wr(IDX_CLK_CFG, 8'h00);
        repeat (40) @(posedge pclk);
        `CHK(blank, 1'b1)
        wr(IDX_CLK_CFG, 8'h40);
        repeat (40) @(posedge pclk);
        `CHK(blank, 1'b0)
        for (int i = 0; i < 5; i++) begin
            wr(IDX_CLK_CFG, (i < 4) ? {2'h2, i[1:0], 4'h0} : 8'hC0);
            half();
            half();
            `CHK(n >= hv[i] * 4 - 4 && n <= hv[i] * 4 + 4, 1'b1)
        end
        wr(IDX_MAIN_CFG, 8'h80);
        repeat (40) @(posedge pclk);
        `CHK(blank, 1'b0)
        $display("test blink done");
        wr(IDX_CLK_CFG, 8'h0F);
        n = 0;
        while (glass.frame_tick !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        n = 1;
        while (glass.frame_tick !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        `CHK(n, 128)
        wr(IDX_MAIN_CFG, 8'h83);
        repeat (4) @(posedge pclk);
        `CHK(bp_used, 3'h4)
        `CHK({glass.pin28_bp, glass.pin27_bp}, 2'h3)
        `CHK(glass.line_is_lcd[28:26], 3'h1)
        wr(IDX_MAIN_CFG, 8'h82);
        repeat (4) @(posedge pclk);
        `CHK({glass.bp_active, glass.pin27_bp}, 5'h0E)
        `CHK(glass.line_is_lcd[28:26], 3'h3)
        wr(IDX_SEG_EN_A, 8'hFC);
        wr(IDX_SEG_EN_B, 8'h0F);
        repeat (4) @(posedge pclk);
        `CHK(glass.line_is_lcd[25:16], 10'h3FF)
        wr(IDX_AUX_X, 8'h01);
        repeat (4) @(posedge pclk);
        `CHK({glass.ext_ladder, glass.bias_comp_en}, 2'h2)
        wr(IDX_MAIN_CFG, 8'h88);
        repeat (4) @(posedge pclk);
        wr(IDX_PTR, 8'h01);
        rd(IDX_DATA, 8'h00);
        repeat (40) @(posedge pclk);
        `CHK(blank, 1'b1)
        $display("test frame mux clear done");
        stop_test();
    end
endmodule : test_lcdsm_top

`default_nettype wire
